/* verilog/rbt_transceiver.sv */
// Top of the 16-bit registered bus transceiver, both directions
// Operation
// - The A-to-B register loads the A pins on a rising A-to-B capture clock only while its capture enable is low.
// - While the A-to-B output enable is low the B pins are driven with the A-to-B register.
// - Without an enabled rising edge the register keeps its contents and the outputs their level.
// - With the A-to-B output enable high the B outputs float whatever the other inputs do.
// - The B-to-A path works the same way with its own controls and drives the A pins.
// - Each pin is both a data input of one path and a three-state output of the other.
// - Two 8-bit halves share every control line, so they capture and drive together.
// - In the bus-hold build each data input keeps its last driven level when released.
module rbt_transceiver (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          bus_hold_enable_in,
  input  wire logic                          a_to_b_capture_clock_in,
  input  wire logic                          a_to_b_capture_enable_n_in,
  input  wire logic                          a_to_b_output_enable_n_in,
  input  wire logic                          b_to_a_capture_clock_in,
  input  wire logic                          b_to_a_capture_enable_n_in,
  input  wire logic                          b_to_a_output_enable_n_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] a_pin_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] a_pin_driven_in,
  output logic [rbt_pkg::BUS_WIDTH-1:0]      a_pin_out,
  output logic [rbt_pkg::BUS_WIDTH-1:0]      a_pin_oe_out,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] b_pin_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] b_pin_driven_in,
  output logic [rbt_pkg::BUS_WIDTH-1:0]      b_pin_out,
  output logic [rbt_pkg::BUS_WIDTH-1:0]      b_pin_oe_out
);
  rbt_pkg::rbt_ctrl_type         ctrl_ab;
  rbt_pkg::rbt_ctrl_type         ctrl_ba;
  rbt_pkg::rbt_drive_type        drive_ab;
  rbt_pkg::rbt_drive_type        drive_ba;
  logic [rbt_pkg::BUS_WIDTH-1:0] held_a;
  logic [rbt_pkg::BUS_WIDTH-1:0] held_b;
  logic [rbt_pkg::BUS_WIDTH-1:0] a_seen;
  logic [rbt_pkg::BUS_WIDTH-1:0] b_seen;
  logic [rbt_pkg::BUS_WIDTH-1:0] stored_ab;
  logic [rbt_pkg::BUS_WIDTH-1:0] stored_ba;
  logic                          cap_ab;
  logic                          cap_ba;

  // Both halves take the same control bundle
  // Enables taken as active low levels, the capture clock as a rising edge
  assign ctrl_ab = '{capture_clock: a_to_b_capture_clock_in,
                     capture_enable_n: a_to_b_capture_enable_n_in,
                     output_enable_n: a_to_b_output_enable_n_in};
  assign ctrl_ba = '{capture_clock: b_to_a_capture_clock_in,
                     capture_enable_n: b_to_a_capture_enable_n_in,
                     output_enable_n: b_to_a_output_enable_n_in};

  // Bus hold keepers, one per bit; a pin we drive ourselves feeds back our value
  genvar i;
  generate
    for (i = 0; i < rbt_pkg::BUS_WIDTH; i++) begin : g_hold
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          held_a[i] <= rbt_pkg::HOLD_RESET[i];
          held_b[i] <= rbt_pkg::HOLD_RESET[i];
        end else begin
          if (a_pin_driven_in[i] || a_pin_oe_out[i]) begin
            held_a[i] <= a_seen[i];
          end
          if (b_pin_driven_in[i] || b_pin_oe_out[i]) begin
            held_b[i] <= b_seen[i];
          end
        end
      end
      // Released pin reads the kept level; plain build passes the pin as is
      assign a_seen[i] = (a_pin_oe_out[i] || a_pin_driven_in[i] || !bus_hold_enable_in)
                         ? (a_pin_oe_out[i] ? a_pin_out[i] : a_pin_in[i]) : held_a[i];
      assign b_seen[i] = (b_pin_oe_out[i] || b_pin_driven_in[i] || !bus_hold_enable_in)
                         ? (b_pin_oe_out[i] ? b_pin_out[i] : b_pin_in[i]) : held_b[i];

      // Kept level must be the one seen on the last driven cycle, not the reset value
      chk_keep_a_bit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ($past(rst_n_in) && bus_hold_enable_in && $past(a_pin_driven_in[i] || a_pin_oe_out[i])
         && !a_pin_driven_in[i] && !a_pin_oe_out[i]) |-> a_seen[i] == $past(a_seen[i]))
        else $error("released A bit lost level");
      chk_keep_b_bit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ($past(rst_n_in) && bus_hold_enable_in && $past(b_pin_driven_in[i] || b_pin_oe_out[i])
         && !b_pin_driven_in[i] && !b_pin_oe_out[i]) |-> b_seen[i] == $past(b_seen[i]))
        else $error("released B bit lost level");
    end
  endgenerate

  // A side feeds A-to-B, B side feeds B-to-A
  rbt_path u_a_to_b (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .ctrl_in     (ctrl_ab),
    .src_data_in (a_seen),
    .drive_out   (drive_ab),
    .stored_out  (stored_ab),
    .capture_out (cap_ab)
  );

  // Mirror path with its own controls
  rbt_path u_b_to_a (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .ctrl_in     (ctrl_ba),
    .src_data_in (b_seen),
    .drive_out   (drive_ba),
    .stored_out  (stored_ba),
    .capture_out (cap_ba)
  );

  // Contention left to the outside logic, no arbitration here
  assign b_pin_out    = drive_ab.data;
  assign b_pin_oe_out = drive_ab.oe;
  assign a_pin_out    = drive_ba.data;
  assign a_pin_oe_out = drive_ba.oe;

  chk_b_drives_reg: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !a_to_b_output_enable_n_in |-> (b_pin_oe_out == '1 && b_pin_out == stored_ab))
    else $error("B pins not showing register");
  chk_a_drives_reg: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !b_to_a_output_enable_n_in |-> (a_pin_oe_out == '1 && a_pin_out == stored_ba))
    else $error("A pins not showing register");
  chk_b_floats: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    a_to_b_output_enable_n_in |-> b_pin_oe_out == '0) else $error("B driven while disabled");
  chk_a_floats: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    b_to_a_output_enable_n_in |-> a_pin_oe_out == '0) else $error("A driven while disabled");
  chk_halves_together: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    cap_ab |=> stored_ab == $past(a_seen)) else $error("halves did not load together");
  // Edge detector restarts high, so a clock high during reset gives no edge at release
  chk_ba_capture: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ($past(rst_n_in) && b_to_a_capture_clock_in && !$past(b_to_a_capture_clock_in)
     && !b_to_a_capture_enable_n_in) |-> cap_ba) else $error("B-to-A edge missed");
  chk_ab_capture: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ($past(rst_n_in) && a_to_b_capture_clock_in && !$past(a_to_b_capture_clock_in)
     && !a_to_b_capture_enable_n_in) |-> cap_ab) else $error("A-to-B edge missed");
  chk_ab_refused: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    a_to_b_capture_enable_n_in |=> $stable(b_pin_out)) else $error("A-to-B loaded while disabled");
  chk_ba_refused: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    b_to_a_capture_enable_n_in |=> $stable(a_pin_out)) else $error("B-to-A loaded while disabled");
  chk_ab_no_edge: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !a_to_b_capture_clock_in |=> $stable(b_pin_out)) else $error("A-to-B loaded with clock low");
  chk_ba_no_edge: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !b_to_a_capture_clock_in |=> $stable(a_pin_out)) else $error("B-to-A loaded with clock low");
  chk_hold_keeps: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (bus_hold_enable_in && !a_pin_driven_in[0] && !a_pin_oe_out[0])
    |-> a_seen[0] == held_a[0]) else $error("released A pin lost level");

  // Neither half may load on its own
  for (genvar h = 0; h < rbt_pkg::HALF_COUNT; h++) begin : g_half
    chk_half_ab_moves: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $changed(stored_ab[h*rbt_pkg::HALF_WIDTH +: rbt_pkg::HALF_WIDTH]) |-> $past(cap_ab))
      else $error("A-to-B half loaded alone");
    chk_half_ba_moves: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $changed(stored_ba[h*rbt_pkg::HALF_WIDTH +: rbt_pkg::HALF_WIDTH]) |-> $past(cap_ba))
      else $error("B-to-A half loaded alone");
  end
endmodule // rbt_transceiver

/* common/rbt_pkg.sv */
// Package of widths, reset values and carriers for the registered bus transceiver
package rbt_pkg;
  localparam int unsigned HALF_WIDTH = 8;
  localparam int unsigned HALF_COUNT = 2;
  localparam int unsigned BUS_WIDTH  = HALF_WIDTH * HALF_COUNT;
  localparam logic [BUS_WIDTH-1:0] REG_RESET = 16'h0000;
  localparam logic [BUS_WIDTH-1:0] HOLD_RESET = 16'h0000;
  localparam logic BUS_HOLD_ON = 1'b1;

  // Control group of one direction, all active low except the clock
  typedef struct packed {
    logic capture_clock;
    logic capture_enable_n;
    logic output_enable_n;
  } rbt_ctrl_type;

  // One direction's pin drive toward the far bus
  typedef struct packed {
    logic [BUS_WIDTH-1:0] data;
    logic [BUS_WIDTH-1:0] oe;
  } rbt_drive_type;

  typedef enum logic [1:0] {
    RBT_EDGE_IDLE = 2'b01,
    RBT_EDGE_HIGH = 2'b10
  } rbt_edge_type;
endpackage

/* verilog/rbt_path.sv */
// One direction of the transceiver: edge detect, capture register and drive
module rbt_path (
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_n_in,
  input  wire rbt_pkg::rbt_ctrl_type        ctrl_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] src_data_in,
  output rbt_pkg::rbt_drive_type            drive_out,
  output logic [rbt_pkg::BUS_WIDTH-1:0]     stored_out,
  output logic                              capture_out
);
  rbt_pkg::rbt_edge_type edge_state;
  logic [rbt_pkg::BUS_WIDTH-1:0] stored;
  logic capture;

  // Capture clock sampled as synchronous input; rising edge is low then high
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_state <= rbt_pkg::RBT_EDGE_HIGH;
    end else begin
      edge_state <= ctrl_in.capture_clock ? rbt_pkg::RBT_EDGE_HIGH : rbt_pkg::RBT_EDGE_IDLE;
    end
  end

  assign capture = ctrl_in.capture_clock && (edge_state == rbt_pkg::RBT_EDGE_IDLE)
                   && !ctrl_in.capture_enable_n;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stored <= rbt_pkg::REG_RESET;
    end else if (capture) begin
      stored <= src_data_in;
    end
  end
  // Otherwise held

  always_comb begin
    drive_out.data = stored;
    drive_out.oe   = {rbt_pkg::BUS_WIDTH{!ctrl_in.output_enable_n}};
  end
  assign stored_out  = stored;
  assign capture_out = capture;

  chk_capture_loads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    capture |=> stored == $past(src_data_in)) else $error("capture not loaded");
  chk_hold_when_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !capture |=> $stable(stored)) else $error("register changed without capture");
  chk_enable_gates: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ctrl_in.capture_enable_n |-> !capture) else $error("capture while disabled");
  chk_edge_needed: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    capture |-> !$past(ctrl_in.capture_clock)) else $error("capture without edge");
  chk_drive_value: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    drive_out.data == stored) else $error("drive differs from register");
  chk_float_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ctrl_in.output_enable_n |-> drive_out.oe == '0) else $error("drive while disabled");
endmodule // rbt_path

/* tb/rbt_bus_model.sv */
// Model of the outside logic on one bus, resolving the shared pin level
module rbt_bus_model (
  input  wire logic                          sys_clk_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] ext_data_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] ext_en_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] dev_data_in,
  input  wire logic [rbt_pkg::BUS_WIDTH-1:0] dev_oe_in,
  output logic [rbt_pkg::BUS_WIDTH-1:0]      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [rbt_pkg::BUS_WIDTH-1:0] last = 16'h0000;
  // Only driven cycles update the remembered level, so a released bit stays put
  always @(posedge sys_clk_in) begin
    last <= ((ext_en_in | dev_oe_in) & pin_out) | (~(ext_en_in | dev_oe_in) & last);
  end
  // No pull on the bus, so a released bit shows the inverse of its last driven level
  assign pin_out = (ext_en_in & ext_data_in) | (~ext_en_in & dev_oe_in & dev_data_in)
                 | (~ext_en_in & ~dev_oe_in & ~last);
endmodule // rbt_bus_model

/* tb/rbt_transceiver_bench.sv */
// Self-checking bench of the registered bus transceiver
module rbt_transceiver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        dir;
    logic        ce_n;
    logic [15:0] data;
    logic [15:0] exp;
  } rbt_row_type;
  localparam rbt_row_type ROWS [6] = '{'{1'b0, 1'b0, 16'h1234, 16'h1234}, '{1'b0, 1'b1, 16'habcd, 16'h1234},
    '{1'b0, 1'b0, 16'h00ff, 16'h00ff}, '{1'b1, 1'b0, 16'hff00, 16'hff00}, '{1'b1, 1'b1, 16'h5555, 16'hff00},
    '{1'b1, 1'b0, 16'h5a5a, 16'h5a5a}};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hold_en = rbt_pkg::BUS_HOLD_ON;
  logic        ab_clk = 1'b1;
  logic        ab_ce_n = 1'b1;
  logic        ab_oe_n = 1'b1;
  logic        ba_clk = 1'b1;
  logic        ba_ce_n = 1'b1;
  logic        ba_oe_n = 1'b1;
  logic [15:0] a_ext = 16'h0000;
  logic [15:0] a_en = 16'h0000;
  logic [15:0] b_ext = 16'h0000;
  logic [15:0] b_en = 16'h0000;
  logic [15:0] a_pin, b_pin, a_out, a_oe, b_out, b_oe;
  int          n_errors = 0;
  int          comparisons = 0;
  always #2 clk = ~clk;
  rbt_transceiver dut (.sys_clk_in(clk), .rst_n_in(rst_n), .bus_hold_enable_in(hold_en),
    .a_to_b_capture_clock_in(ab_clk), .a_to_b_capture_enable_n_in(ab_ce_n), .a_to_b_output_enable_n_in(ab_oe_n),
    .b_to_a_capture_clock_in(ba_clk), .b_to_a_capture_enable_n_in(ba_ce_n), .b_to_a_output_enable_n_in(ba_oe_n),
    .a_pin_in(a_pin), .a_pin_driven_in(a_en), .a_pin_out(a_out), .a_pin_oe_out(a_oe),
    .b_pin_in(b_pin), .b_pin_driven_in(b_en), .b_pin_out(b_out), .b_pin_oe_out(b_oe));
  rbt_bus_model bus_a (.sys_clk_in(clk), .ext_data_in(a_ext), .ext_en_in(a_en), .dev_data_in(a_out),
    .dev_oe_in(a_oe), .pin_out(a_pin));
  rbt_bus_model bus_b (.sys_clk_in(clk), .ext_data_in(b_ext), .ext_en_in(b_en), .dev_data_in(b_out),
    .dev_oe_in(b_oe), .pin_out(b_pin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One capture: clock sampled low, then high; the opposite driver is released first
  task automatic cap(input logic dir, input logic ce_n, input logic [15:0] d, input logic en);
    @(negedge clk);
    ab_oe_n = dir;
    ba_oe_n = ~dir;
    if (dir) begin
      a_en = 16'h0000;
      b_ext = d;
      b_en = {16{en}};
      ba_ce_n = ce_n;
      ba_clk = 1'b0;
    end else begin
      b_en = 16'h0000;
      a_ext = d;
      a_en = {16{en}};
      ab_ce_n = ce_n;
      ab_clk = 1'b0;
    end
    @(negedge clk);
    ab_clk = 1'b1;
    ba_clk = 1'b1;
    @(negedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("Errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk(a_out, rbt_pkg::REG_RESET);
    chk(b_out, rbt_pkg::REG_RESET);
    chk(b_oe, 16'h0000);
    foreach (ROWS[i]) begin
      cap(ROWS[i].dir, ROWS[i].ce_n, ROWS[i].data, 1'b1);
      chk(ROWS[i].dir ? a_out : b_out, ROWS[i].exp);
      chk(ROWS[i].dir ? b_oe : a_oe, 16'h0000);
      chk(ROWS[i].dir ? a_oe : b_oe, 16'hffff);
    end
    // Released B bus shows the inverse of its last level, so only the keeper can supply it
    cap(1'b1, 1'b0, 16'h0000, 1'b0);
    chk(a_out, 16'h5a5a);
    chk(a_pin, 16'h5a5a);
    cap(1'b0, 1'b1, 16'h0000, 1'b1);
    chk(b_pin, 16'h00ff);
    // Plain build passes the released pin, the inverse of the last driven 00ff
    hold_en = 1'b0;
    cap(1'b1, 1'b0, 16'h0000, 1'b0);
    chk(a_out, 16'hff00);
    // Mid-run reset; clocks already high at release must not count as an edge
    rst_n = 1'b0;
    @(negedge clk);
    chk(a_out, rbt_pkg::REG_RESET);
    chk(b_out, rbt_pkg::REG_RESET);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(a_pin, rbt_pkg::REG_RESET);
    end_sim();
  end
endmodule // rbt_transceiver_bench
